/* design/mdio_pkg.sv */
package mdio_pkg;

  // Register addresses (Modbus holding register numbers)
  localparam logic [15:0] MDIO_ADDR_STATUS    = 16'h1f3c;
  localparam logic [15:0] MDIO_ADDR_DIAG_FLAG = 16'h1f3d;
  localparam logic [15:0] MDIO_ADDR_DIAG_LOC  = 16'h1f3e;
  localparam logic [15:0] MDIO_ADDR_IN_IMAGE  = 16'h1f40;
  localparam logic [15:0] MDIO_ADDR_OUT_IMAGE = 16'h2328;

  // Diagnostic flag bit positions, plus the status word error bit
  localparam int MDIO_BIT_OUT_SHORT  = 0;
  localparam int MDIO_BIT_SUP_UNDER  = 2;
  localparam int MDIO_BIT_SUP_SURGE  = 3;
  localparam int MDIO_BIT_SUP_SHORT  = 4;
  localparam int MDIO_BIT_OVERTEMP   = 10;
  localparam int MDIO_BIT_STAT_ERROR = 0;

  // Fault location codes
  localparam logic [15:0] MDIO_LOC_NONE = 16'h0000;

  // Modbus exception codes; MDIO_EXC_BAD_ADDR answers every unmapped read and every write to an address other than MDIO_ADDR_OUT_IMAGE
  localparam logic [7:0] MDIO_EXC_NONE      = 8'h00;
  localparam logic [7:0] MDIO_EXC_BAD_ADDR  = 8'h02;

  // Reset values
  localparam logic [15:0] MDIO_OUT_RESET = 16'h0000;

  // Startup readiness times
  localparam int MDIO_CLK_HZ         = 200_000_000;
  localparam int MDIO_CONN_READY_MS  = 350;
  localparam int MDIO_CYCLIC_READY_MS = 500;
  localparam int MDIO_CONN_READY_CYC   = MDIO_CONN_READY_MS * (MDIO_CLK_HZ / 1000);
  localparam int MDIO_CYCLIC_READY_CYC = MDIO_CYCLIC_READY_MS * (MDIO_CLK_HZ / 1000);

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        byte_wide;
  } mdio_req_t;

  typedef struct packed {
    logic        valid;
    logic        exc;
    logic [7:0]  exc_code;
    logic [15:0] rdata;
  } mdio_rsp_t;

  typedef struct packed {
    logic [3:0] out_group_short;
    logic       sup_under;
    logic       sup_surge;
    logic       sup_short;
    logic       overtemp;
  } mdio_fault_t;

endpackage : mdio_pkg

/* design/mdio_sync.sv */
`timescale 1ns/1ps
module mdio_sync
  import mdio_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : mdio_sync

/* design/mdio_ready_timer.sv */
`timescale 1ns/1ps
module mdio_ready_timer
  import mdio_pkg::*;
#(
  parameter int COUNT = 1
)(
  input  wire logic clock,
  input  wire logic rstn,
  output logic      done
);

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] count;

  // Counts once from reset release, then holds
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      count <= '0;
      done  <= 1'b0;
    end
    else if (!done)
    begin
      if (count == LAST)
        done <= 1'b1;
      else
        count <= count + CW'(1);
    end
  end

endmodule : mdio_ready_timer

/* design/mdio_process_image.sv */
`timescale 1ns/1ps
module mdio_process_image
  import mdio_pkg::*;
#(
  parameter int CHANNELS        = 16,
  parameter int CONN_READY_CYC  = MDIO_CONN_READY_CYC,
  parameter int CYCLIC_READY_CYC = MDIO_CYCLIC_READY_CYC
)(
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire mdio_req_t           req,
  output mdio_rsp_t                rsp,
  input  wire logic [CHANNELS-1:0] pin_in,
  output logic      [CHANNELS-1:0] pin_out,
  output logic      [CHANNELS-1:0] pin_oe,
  input  wire mdio_fault_t         fault_in,
  output logic                     conn_ready,
  output logic                     cyclic_ready
);

  localparam int GROUPS = CHANNELS / 4;

  logic [CHANNELS-1:0] pin_sync;
  logic [7:0]          fault_sync;
  mdio_fault_t         fault;
  logic [15:0]         output_image_word;
  logic [CHANNELS-1:0] channel_is_output;
  logic [15:0]         input_image_word;
  logic [15:0]         diag_fault_flags;
  logic [15:0]         diag_fault_location;
  logic [15:0]         status_word;
  logic [15:0]         next_rdata;
  logic                next_exc;
  logic                wr_out;

  mdio_sync #(
    .WIDTH (CHANNELS)
  ) u_pin_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  mdio_sync #(
    .WIDTH (8)
  ) u_fault_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (fault_in),
    .sync_out (fault_sync)
  );

  assign fault = mdio_fault_t'(fault_sync);

  mdio_ready_timer #(
    .COUNT (CONN_READY_CYC)
  ) u_conn_timer (
    .clock (clock),
    .rstn  (rstn),
    .done  (conn_ready)
  );

  mdio_ready_timer #(
    .COUNT (CYCLIC_READY_CYC)
  ) u_cyclic_timer (
    .clock (clock),
    .rstn  (rstn),
    .done  (cyclic_ready)
  );

  function automatic logic is_read_only(input logic [15:0] addr);
    is_read_only = (addr == MDIO_ADDR_STATUS) || (addr == MDIO_ADDR_DIAG_FLAG) ||
                   (addr == MDIO_ADDR_DIAG_LOC) || (addr == MDIO_ADDR_IN_IMAGE);
  endfunction : is_read_only

  function automatic logic is_mapped(input logic [15:0] addr);
    is_mapped = is_read_only(addr) || (addr == MDIO_ADDR_OUT_IMAGE);
  endfunction : is_mapped

  assign wr_out = req.valid && req.write && (req.addr == MDIO_ADDR_OUT_IMAGE) && cyclic_ready;

  // Output word; byte-wide writes keep only the low byte
  always_ff @(posedge clock)
  begin
    if (!rstn)
      output_image_word <= MDIO_OUT_RESET;
    else if (wr_out)
    begin
      if (req.byte_wide)
        output_image_word <= {8'h00, req.wdata[7:0]};
      else
        output_image_word <= req.wdata;
    end
  end

  // A channel turns into an output the first time the client sets its bit;
  // clearing the bit drops the driver so the pin can be read again.
  always_comb
  begin
    channel_is_output = output_image_word[CHANNELS-1:0];
  end

  assign pin_out = output_image_word[CHANNELS-1:0];
  assign pin_oe  = channel_is_output;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_in
      // Driven channels show their commanded state
      assign input_image_word[g] = channel_is_output[g] ? output_image_word[g] : pin_sync[g];
    end
  endgenerate

  always_comb
  begin
    diag_fault_flags = 16'h0000;
    diag_fault_flags[MDIO_BIT_OUT_SHORT] = |fault.out_group_short;
    diag_fault_flags[MDIO_BIT_SUP_UNDER] = fault.sup_under;
    diag_fault_flags[MDIO_BIT_SUP_SURGE] = fault.sup_surge;
    diag_fault_flags[MDIO_BIT_SUP_SHORT] = fault.sup_short;
    diag_fault_flags[MDIO_BIT_OVERTEMP]  = fault.overtemp;
  end

  // Only one group can be reported; the lowest group wins
  always_comb
  begin
    diag_fault_location = MDIO_LOC_NONE;
    for (int i = GROUPS - 1; i >= 0; i--)
    begin
      if (fault.out_group_short[i])
        diag_fault_location = 16'(i + 1);
    end
  end

  always_comb
  begin
    status_word = 16'h0000;
    status_word[MDIO_BIT_STAT_ERROR] = |diag_fault_flags;
  end

  always_comb
  begin
    next_rdata = 16'h0000;
    next_exc   = 1'b0;
    if (req.write)
      next_exc = is_read_only(req.addr) || !is_mapped(req.addr);
    else
    begin
      case (req.addr)
        MDIO_ADDR_STATUS:    next_rdata = status_word;
        MDIO_ADDR_DIAG_FLAG: next_rdata = diag_fault_flags;
        MDIO_ADDR_DIAG_LOC:  next_rdata = diag_fault_location;
        MDIO_ADDR_IN_IMAGE:  next_rdata = input_image_word;
        MDIO_ADDR_OUT_IMAGE: next_rdata = output_image_word;
        default:             next_exc   = 1'b1;
      endcase
      if (req.byte_wide)
        next_rdata[15:8] = 8'h00;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      rsp <= '0;
    else
    begin
      rsp.valid    <= req.valid && conn_ready;
      rsp.exc      <= next_exc;
      rsp.exc_code <= next_exc ? MDIO_EXC_BAD_ADDR : MDIO_EXC_NONE;
      rsp.rdata    <= next_rdata;
    end
  end

endmodule : mdio_process_image

/* verification/mdio_process_image_chk.sv */
`timescale 1ns/1ps
module mdio_process_image_chk
  import mdio_pkg::*;
#(
  parameter int CHANNELS         = 16,
  parameter int CONN_READY_CYC   = 10,
  parameter int CYCLIC_READY_CYC = 20
)(
  input wire logic                clock,
  input wire logic                rstn,
  input wire mdio_req_t           req,
  input wire mdio_rsp_t           rsp,
  input wire logic [CHANNELS-1:0] pin_in,
  input wire logic [CHANNELS-1:0] pin_out,
  input wire logic [CHANNELS-1:0] pin_oe,
  input wire mdio_fault_t         fault_in,
  input wire logic                conn_ready,
  input wire logic                cyclic_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Faults as the answer sees them: two sync stages plus the read
  mdio_fault_t fd [3];
  always_ff @(posedge clock)
    fd <= '{fault_in, fd[0], fd[1]};
  a_answer_next: assert property (rsp.valid == $past(req.valid && conn_ready)) else $error("answer");
  a_ro_refused: assert property (rsp.valid && $past(req.write) && $past(req.addr) != MDIO_ADDR_OUT_IMAGE
    |-> rsp.exc && rsp.exc_code == MDIO_EXC_BAD_ADDR) else $error("refusal");
  a_word_write: assert property (req.valid && req.write && req.addr == MDIO_ADDR_OUT_IMAGE && cyclic_ready
    && !req.byte_wide |=> pin_out == $past(req.wdata)) else $error("word");
  a_byte_write: assert property (req.valid && req.write && req.addr == MDIO_ADDR_OUT_IMAGE && cyclic_ready
    && req.byte_wide |=> pin_out == ($past(req.wdata) & 16'h00ff)) else $error("byte");
  a_oe_follows: assert property (pin_oe == pin_out) else $error("oe");
  a_diag_flags: assert property (rsp.valid && !rsp.exc && $past(req.addr) == MDIO_ADDR_DIAG_FLAG
    |-> rsp.rdata == {5'h00, fd[2].overtemp, 5'h00, fd[2].sup_short, fd[2].sup_surge, fd[2].sup_under,
    1'b0, |fd[2].out_group_short}) else $error("flags");
  a_fault_loc: assert property (rsp.valid && !rsp.exc && $past(req.addr) == MDIO_ADDR_DIAG_LOC
    |-> rsp.rdata == (fd[2].out_group_short[0] ? 16'h0001 : fd[2].out_group_short[1] ? 16'h0002 :
    fd[2].out_group_short[2] ? 16'h0003 : fd[2].out_group_short[3] ? 16'h0004 : MDIO_LOC_NONE))
    else $error("location");
  a_status_error: assert property (rsp.valid && !rsp.exc && $past(req.addr) == MDIO_ADDR_STATUS
    |-> rsp.rdata[0] == |fd[2]) else $error("status");
endmodule : mdio_process_image_chk
bind mdio_process_image mdio_process_image_chk #(.CHANNELS(CHANNELS), .CONN_READY_CYC(CONN_READY_CYC),
  .CYCLIC_READY_CYC(CYCLIC_READY_CYC)) u_chk (.clock(clock), .rstn(rstn), .req(req), .rsp(rsp),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .fault_in(fault_in), .conn_ready(conn_ready),
  .cyclic_ready(cyclic_ready));

/* verification/mdio_client.sv */
`timescale 1ns/1ps
module mdio_client
  import mdio_pkg::*;
(
  input  wire logic      clock,
  input  wire mdio_rsp_t rsp,
  output mdio_req_t      req
);
  initial req = '0;
  // One request per call, with an idle cycle after it
  task automatic xfer(input logic wr, input logic [15:0] a, d, input logic bw, output mdio_rsp_t r);
    @(negedge clock);
    req <= '{1'b1, wr, a, d, bw};
    @(negedge clock);
    req <= '0;
    r = rsp;
  endtask : xfer
endmodule : mdio_client

/* verification/test_modbus_dio16_process_image.sv */
`timescale 1ns/1ps
module test_modbus_dio16_process_image;
  import mdio_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] sensor = 16'h0000;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  mdio_fault_t fault_in = '0;
  mdio_req_t   req;
  mdio_rsp_t   rsp;
  mdio_rsp_t   r;
  logic        conn_ready;
  logic        cyclic_ready;
  int          n_errors = 0;
  int          cmp_count = 0;
  // Read-only registers plus one unmapped number, all refused on write
  logic [15:0] ro_addr [5] = '{MDIO_ADDR_STATUS, MDIO_ADDR_DIAG_FLAG, MDIO_ADDR_DIAG_LOC, MDIO_ADDR_IN_IMAGE,
                               16'h0000};
  always #2.5 clock = ~clock;
  // Field wiring: a driven channel reads back what it drives
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & sensor);
  mdio_client cl (.clock(clock), .rsp(rsp), .req(req));
  mdio_process_image #(.CONN_READY_CYC(10), .CYCLIC_READY_CYC(20)) dut_u (.clock(clock), .rstn(rstn),
    .req(req), .rsp(rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .fault_in(fault_in),
    .conn_ready(conn_ready), .cyclic_ready(cyclic_ready));
  task automatic chk(input string what, input logic [17:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [15:0] a, e);
    cl.xfer(1'b0, a, 16'h0000, 1'b0, r);
    chk($sformatf("read %h", a), {r.valid, r.exc, r.rdata}, {2'b10, e});
  endtask : rd
  task automatic wr(input logic [15:0] a, d, input logic bw, input logic [7:0] code);
    cl.xfer(1'b1, a, d, bw, r);
    chk($sformatf("write %h", a), {r.valid, r.exc, 8'h00, r.exc_code}, {1'b1, code != 8'h00, 8'h00, code});
  endtask : wr
  task automatic fl(input mdio_fault_t f, input logic [15:0] flags, loc);
    fault_in = f;
    repeat (4) @(negedge clock);
    rd(MDIO_ADDR_DIAG_FLAG, flags);
    rd(MDIO_ADDR_DIAG_LOC, loc);
    rd(MDIO_ADDR_STATUS, {15'h0000, flags != 16'h0000});
  endtask : fl
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  initial
  begin
    #20000;
    n_errors++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    cl.xfer(1'b0, MDIO_ADDR_STATUS, 16'h0000, 1'b0, r);
    chk("early answer", {17'h00000, r.valid}, 18'h00000);
    for (int i = 0; i < 50 && !conn_ready; i++) @(negedge clock);
    wr(MDIO_ADDR_OUT_IMAGE, 16'hffff, 1'b0, MDIO_EXC_NONE);
    for (int i = 0; i < 50 && !cyclic_ready; i++) @(negedge clock);
    rd(MDIO_ADDR_OUT_IMAGE, 16'h0000);
    sensor = 16'h1a0c;
    wr(MDIO_ADDR_OUT_IMAGE, 16'ha5c3, 1'b0, MDIO_EXC_NONE);
    rd(MDIO_ADDR_OUT_IMAGE, 16'ha5c3);
    chk("pins", {2'b00, pin_out}, 18'h0a5c3);
    repeat (4) @(negedge clock);
    rd(MDIO_ADDR_IN_IMAGE, 16'hbfcf);
    wr(MDIO_ADDR_OUT_IMAGE, 16'h0000, 1'b0, MDIO_EXC_NONE);
    repeat (4) @(negedge clock);
    rd(MDIO_ADDR_IN_IMAGE, 16'h1a0c);
    wr(MDIO_ADDR_OUT_IMAGE, 16'h12ab, 1'b1, MDIO_EXC_NONE);
    rd(MDIO_ADDR_OUT_IMAGE, 16'h00ab);
    foreach (ro_addr[i])
      wr(ro_addr[i], 16'hffff, 1'b0, MDIO_EXC_BAD_ADDR);
    rd(MDIO_ADDR_OUT_IMAGE, 16'h00ab);
    fl(8'h08, 16'h0004, 16'h0000);
    fl(8'h04, 16'h0008, 16'h0000);
    fl(8'h02, 16'h0010, 16'h0000);
    fl(8'h01, 16'h0400, 16'h0000);
    for (int g = 0; g < 4; g++) fl(mdio_fault_t'(8'h10 << g), 16'h0001, 16'(g + 1));
    fl(8'h00, 16'h0000, 16'h0000);
    complete_run();
  end
endmodule : test_modbus_dio16_process_image
